// file: core/htf_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the HDLC
  transmit FIFO, host side.
  Assumes a 125 MHz core clock and an 8-bit byte register address.
*/
`ifndef HTF_CFG_SVH
`define HTF_CFG_SVH

// Register byte offsets
`define HTF_OFF_CTRL 8'hA0
`define HTF_OFF_DATA 8'hA2
`define HTF_OFF_STAT 8'hA4
`define HTF_OFF_STKY 8'hA6
`define HTF_OFF_IEN 8'hA8

// Data register fields
`define HTF_DAT_BYTE_HI 15
`define HTF_DAT_BYTE_LO 8
`define HTF_DAT_LAST 0

// Control register fields
`define HTF_CTL_THR_HI 12
`define HTF_CTL_THR_LO 8
`define HTF_CTL_MSB 3
`define HTF_CTL_SRST 0
`define HTF_THR_RST 5'h10

// Event bit positions, shared by sticky and enable registers
`define HTF_EV_SPACE 0
`define HTF_EV_EMPTY 1
`define HTF_EV_FULL 2
`define HTF_EV_PEND 3
`define HTF_EV_UNF 4
`define HTF_EV_OVF 5
`define HTF_EV_W 6

// FIFO geometry
`define HTF_DEPTH 9'h100
`define HTF_PTR_W 8
`define HTF_CNT_W 9
`define HTF_ONE_CNT 9'h001
`define HTF_ZERO_CNT 9'h000

// RAM power-up wait after soft reset release
`define HTF_CLK_NS 8
`define HTF_RAMUP_NS 40
`define HTF_RAMUP_CYC ((`HTF_RAMUP_NS + `HTF_CLK_NS - 1) / `HTF_CLK_NS)

`endif

// file: core/htf_pkg.sv
/*
  Types of the HDLC transmit FIFO: operating modes and the module state.
  Assumes htf_cfg.svh is on the include path.
*/
`include "htf_cfg.svh"

package htf_pkg;

  // Soft reset sequencing
  typedef enum logic [1:0] {
    HTF_RUN,
    HTF_HELD,
    HTF_PWRUP,
    HTF_SEEK
  } htf_mode_e;

  // Whole state of the FIFO block
  typedef struct packed {
    logic [255:0][8:0] mem;
    logic [`HTF_PTR_W-1:0] wp;
    logic [`HTF_PTR_W-1:0] rp;
    logic [`HTF_CNT_W-1:0] cnt;
    logic [4:0] thr;
    logic msb_first;
    logic soft_rst;
    logic [`HTF_EV_W-1:0] sticky;
    logic [`HTF_EV_W-1:0] ien;
    logic last_mark;
    logic host_in_pkt;
    htf_mode_e mode;
    logic [3:0] pwr_cnt;
    logic prev_empty;
    logic prev_space;
    logic prev_full;
    logic [7:0] sh;
    logic [2:0] bits_left;
    logic sh_msb;
    logic sh_last;
    logic tx_in_pkt;
    logic bit_val;
    logic bit_valid;
    logic bit_last;
    logic [15:0] rdata;
  } htf_state_s;

endpackage : htf_pkg

// file: core/htf_tx_fifo.sv
/*
  HDLC transmit FIFO, host side: 256-byte buffer filled through a data
  register, drained bit by bit by the packet processor, with live status,
  sticky events and one level interrupt.
  Assumes a single clock, a register master that never waits and a packet
  processor that requests one bit per pulse.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module htf_tx_fifo
  import htf_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [1:0] reg_be_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic port_global_irq_en_in,
  input wire logic tx_bit_req_in,
  output logic tx_bit_out,
  output logic tx_bit_valid_out,
  output logic tx_bit_pkt_end_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the write and read paths
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  htf_state_s s_q;
  htf_state_s s_d;

  logic [`HTF_CNT_W-1:0] free_bytes;
  logic [`HTF_CNT_W-1:0] thr_bytes;
  logic [5:0] tx_free_groups;
  logic tx_fifo_full;
  logic tx_fifo_empty;
  logic tx_space_ok;
  logic data_wr_hi;
  logic wr_open;
  logic push;
  logic pop;
  logic need_byte;
  logic underflow;
  logic overflow;
  logic [`HTF_EV_W-1:0] events;
  logic [8:0] head;
  logic [7:0] tx_byte_value;
  logic tx_byte_is_last;

  ////////////////////////////////////////////////////////////////////////////
  // Live status
  assign free_bytes = `HTF_DEPTH - s_q.cnt;
  assign tx_free_groups = free_bytes[8:3];
  assign tx_fifo_full = (s_q.cnt == `HTF_DEPTH);
  assign tx_fifo_empty = (s_q.cnt == `HTF_ZERO_CNT);
  assign thr_bytes = {1'b0, s_q.thr, 3'b000} + `HTF_ONE_CNT;
  assign tx_space_ok = (free_bytes >= thr_bytes);

  // Write acceptance: held mode drops all, seek mode waits for a packet start
  assign tx_byte_value = reg_wdata_in[`HTF_DAT_BYTE_HI:`HTF_DAT_BYTE_LO];
  assign tx_byte_is_last = reg_be_in[0] ? reg_wdata_in[`HTF_DAT_LAST] : s_q.last_mark;
  assign data_wr_hi = reg_wr_in && reg_be_in[1] && reg_hit(reg_addr_in, `HTF_OFF_DATA);
  assign wr_open = (s_q.mode == HTF_RUN) || (s_q.mode == HTF_SEEK && !s_q.host_in_pkt);
  assign overflow = data_wr_hi && wr_open && tx_fifo_full;
  assign push = data_wr_hi && wr_open && !tx_fifo_full;

  // Drain side: a new byte is needed when the shifter has run dry
  assign need_byte = tx_bit_req_in && (s_q.bits_left == 3'h0) && (s_q.mode != HTF_HELD);
  assign pop = need_byte && !tx_fifo_empty;
  assign underflow = need_byte && tx_fifo_empty && s_q.tx_in_pkt;
  assign head = s_q.mem[s_q.rp];

  // Event sources
  always_comb begin
    events = '0;
    events[`HTF_EV_OVF] = overflow;
    events[`HTF_EV_UNF] = underflow;
    events[`HTF_EV_PEND] = pop && head[8];
    events[`HTF_EV_FULL] = tx_fifo_full && !s_q.prev_full;
    events[`HTF_EV_EMPTY] = tx_fifo_empty && !s_q.prev_empty;
    events[`HTF_EV_SPACE] = tx_space_ok && !s_q.prev_space;
    if (s_q.mode == HTF_HELD && !s_q.soft_rst) begin
      events[`HTF_EV_EMPTY] = 1'b1;
      events[`HTF_EV_SPACE] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.prev_empty = tx_fifo_empty;
    s_d.prev_space = tx_space_ok;
    s_d.prev_full = tx_fifo_full;
    s_d.bit_valid = 1'b0;
    s_d.bit_last = 1'b0;
    s_d.rdata = 16'h0000;

    // Register writes
    if (reg_wr_in && reg_hit(reg_addr_in, `HTF_OFF_CTRL)) begin
      if (reg_be_in[1]) begin
        s_d.thr = reg_wdata_in[`HTF_CTL_THR_HI:`HTF_CTL_THR_LO];
      end
      if (reg_be_in[0]) begin
        s_d.msb_first = reg_wdata_in[`HTF_CTL_MSB];
        s_d.soft_rst = reg_wdata_in[`HTF_CTL_SRST];
      end
    end
    if (reg_wr_in && reg_be_in[0] && reg_hit(reg_addr_in, `HTF_OFF_IEN)) begin
      s_d.ien = reg_wdata_in[`HTF_EV_W-1:0];
    end
    if (reg_wr_in && reg_be_in[0] && reg_hit(reg_addr_in, `HTF_OFF_DATA)) begin
      s_d.last_mark = reg_wdata_in[`HTF_DAT_LAST];
    end

    // Sticky events: clear by one, a new event wins
    if (reg_wr_in && reg_be_in[0] && reg_hit(reg_addr_in, `HTF_OFF_STKY)) begin
      s_d.sticky = s_q.sticky & ~reg_wdata_in[`HTF_EV_W-1:0];
    end
    s_d.sticky = s_d.sticky | events;

    // Host packet tracking, kept across soft reset
    if (data_wr_hi && s_q.mode != HTF_HELD) begin
      s_d.host_in_pkt = !tx_byte_is_last;
    end

    // Push
    if (push) begin
      s_d.mem[s_q.wp] = {tx_byte_is_last, tx_byte_value};
      s_d.wp = s_q.wp + 8'h01;
    end

    // Serializer
    if (tx_bit_req_in && s_q.mode != HTF_HELD) begin
      if (s_q.bits_left != 3'h0) begin
        s_d.bits_left = s_q.bits_left - 3'h1;
        s_d.bit_valid = 1'b1;
        if (s_q.sh_msb) begin
          s_d.bit_val = s_q.sh[7];
          s_d.sh = {s_q.sh[6:0], 1'b0};
        end else begin
          s_d.bit_val = s_q.sh[0];
          s_d.sh = {1'b0, s_q.sh[7:1]};
        end
        s_d.bit_last = s_q.sh_last && (s_q.bits_left == 3'h1);
      end else if (pop) begin
        s_d.rp = s_q.rp + 8'h01;
        s_d.tx_in_pkt = !head[8];
        s_d.sh_msb = s_q.msb_first;
        s_d.sh_last = head[8];
        s_d.bits_left = 3'h7;
        s_d.bit_valid = 1'b1;
        if (s_q.msb_first) begin
          s_d.bit_val = head[7];
          s_d.sh = {head[6:0], 1'b0};
        end else begin
          s_d.bit_val = head[0];
          s_d.sh = {1'b0, head[7:1]};
        end
      end
    end
    if (underflow) begin
      s_d.tx_in_pkt = 1'b0;  // Packet lost, restart on next byte
    end

    // Occupancy
    s_d.cnt = s_q.cnt + (push ? `HTF_ONE_CNT : `HTF_ZERO_CNT) - (pop ? `HTF_ONE_CNT : `HTF_ZERO_CNT);

    // Soft reset sequencing
    unique case (s_q.mode)
      HTF_RUN, HTF_SEEK: begin
        if (s_q.soft_rst) begin
          s_d.mode = HTF_HELD;
        end else if (push) begin
          s_d.mode = HTF_RUN;
        end
      end
      HTF_HELD: begin
        if (!s_q.soft_rst) begin
          s_d.mode = HTF_PWRUP;
          s_d.pwr_cnt = 4'(`HTF_RAMUP_CYC);
        end
      end
      HTF_PWRUP: begin
        if (s_q.soft_rst) begin
          s_d.mode = HTF_HELD;
        end else if (s_q.pwr_cnt == 4'h1) begin
          s_d.mode = HTF_SEEK;
        end
        s_d.pwr_cnt = s_q.pwr_cnt - 4'h1;
      end
    endcase
    if (s_q.soft_rst || s_q.mode == HTF_HELD) begin
      // Flush and halt
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
      s_d.bits_left = 3'h0;
      s_d.tx_in_pkt = 1'b0;
      s_d.bit_valid = 1'b0;
      s_d.bit_last = 1'b0;  // A cut byte never shows a packet end
    end

    // Register reads, data one cycle later
    if (reg_rd_in) begin
      if (reg_hit(reg_addr_in, `HTF_OFF_CTRL)) begin
        s_d.rdata[`HTF_CTL_THR_HI:`HTF_CTL_THR_LO] = s_q.thr;
        s_d.rdata[`HTF_CTL_MSB] = s_q.msb_first;
        s_d.rdata[`HTF_CTL_SRST] = s_q.soft_rst;
      end else if (reg_hit(reg_addr_in, `HTF_OFF_STAT)) begin
        s_d.rdata = {2'b00, tx_free_groups, 5'b00000, tx_fifo_full, tx_fifo_empty, tx_space_ok};
      end else if (reg_hit(reg_addr_in, `HTF_OFF_STKY)) begin
        s_d.rdata[`HTF_EV_W-1:0] = s_q.sticky;
      end else if (reg_hit(reg_addr_in, `HTF_OFF_IEN)) begin
        s_d.rdata[`HTF_EV_W-1:0] = s_q.ien;
      end
      // Data register and unmapped addresses read zero
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
      s_q.thr <= `HTF_THR_RST;
      s_q.mode <= HTF_RUN;
      s_q.prev_empty <= 1'b1;
      s_q.prev_space <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign reg_rdata_out = s_q.rdata;
  assign tx_bit_out = s_q.bit_val;
  assign tx_bit_valid_out = s_q.bit_valid;
  assign tx_bit_pkt_end_out = s_q.bit_last;
  assign irq_out = port_global_irq_en_in && |(s_q.sticky & s_q.ien);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  sequence data_rd_seq;
    reg_rd_in && reg_hit(reg_addr_in, `HTF_OFF_DATA);
  endsequence
  sequence full_wr_seq;
    data_wr_hi && wr_open && tx_fifo_full;
  endsequence

  AST_DATA_READS_ZERO: assert property (data_rd_seq |=> reg_rdata_out == 16'h0000)
    else $error("data register read not zero");
  AST_PUSH_ONLY_HI: assert property (!data_wr_hi && !pop && !s_q.soft_rst && s_q.mode != HTF_HELD
      |=> s_q.cnt == $past(s_q.cnt))
    else $error("occupancy moved without push or pop");
  AST_FULL_FLAG: assert property (data_rd_seq or (reg_rd_in && reg_hit(reg_addr_in, `HTF_OFF_STAT))
      |=> reg_rdata_out[2] == ($past(s_q.cnt) == `HTF_DEPTH) || $past(!reg_hit(reg_addr_in, `HTF_OFF_STAT)))
    else $error("full flag wrong");
  AST_EMPTY_FLAG: assert property (reg_rd_in && reg_hit(reg_addr_in, `HTF_OFF_STAT)
      |=> reg_rdata_out[1] == ($past(s_q.cnt) == `HTF_ZERO_CNT))
    else $error("empty flag wrong");
  AST_GROUPS: assert property (reg_rd_in && reg_hit(reg_addr_in, `HTF_OFF_STAT)
      |=> reg_rdata_out[13:8] == 6'((`HTF_DEPTH - $past(s_q.cnt)) >> 3))
    else $error("free group count wrong");
  AST_SPACE_FLAG: assert property (tx_space_ok == ((9'h100 - s_q.cnt) > {1'b0, s_q.thr, 3'b000}))
    else $error("space flag disagrees with threshold");
  AST_OVERFLOW: assert property (full_wr_seq |=> s_q.sticky[`HTF_EV_OVF] && s_q.cnt == `HTF_DEPTH - $past(9'(pop)))
    else $error("overflow not latched or byte stored");
  AST_UNDERFLOW: assert property (tx_bit_req_in && s_q.bits_left == 3'h0 && tx_fifo_empty && s_q.tx_in_pkt
      && !s_q.soft_rst && s_q.mode != HTF_HELD |=> s_q.sticky[`HTF_EV_UNF] && !tx_bit_valid_out)
    else $error("underflow not latched");
  AST_PKT_END: assert property (pop && head[8] |=> s_q.sticky[`HTF_EV_PEND] ##7 1'b1)
    else $error("packet end not latched");
  AST_RELEASE: assert property (s_q.mode == HTF_HELD && !s_q.soft_rst
      |=> s_q.sticky[`HTF_EV_EMPTY] && s_q.sticky[`HTF_EV_SPACE])
    else $error("release did not set empty and space events");
  AST_IRQ: assert property (irq_out |-> port_global_irq_en_in && (s_q.sticky & s_q.ien) != '0)
    else $error("interrupt without enabled event");
  AST_HELD_DROPS: assert property (s_q.mode == HTF_HELD |=> s_q.cnt == `HTF_ZERO_CNT)
    else $error("held FIFO not empty");
  AST_SET_WINS: assert property (events[`HTF_EV_OVF] |=> s_q.sticky[`HTF_EV_OVF])
    else $error("event lost against clear");
  AST_LSB_FIRST: assert property (pop && !s_q.msb_first && !s_q.soft_rst |=> tx_bit_out == $past(head[0]))
    else $error("first bit not LSB");
  AST_FULL_EVENT: assert property (tx_fifo_full && !s_q.prev_full |=> s_q.sticky[`HTF_EV_FULL])
    else $error("full event not latched");

  ////////////////////////////////////////////////////////////////////////////
  // Further checks on serial order, events, status and soft reset

  // Byte load and packet-end steps of the serializer
  sequence msb_load_seq;
    pop && s_q.msb_first && !s_q.soft_rst;
  endsequence
  sequence end_mark_seq;
    tx_bit_pkt_end_out;
  endsequence

  // Reordered bytes start with their top bit
  AST_MSB_FIRST: assert property (msb_load_seq |=> tx_bit_out == $past(head[7]))
    else $error("first bit not MSB");

  // A packet-end marker only rides on a delivered bit
  AST_END_ON_BIT: assert property (end_mark_seq |-> tx_bit_valid_out)
    else $error("packet end without a bit");

  // Empty flag rising is latched
  AST_EMPTY_RISE: assert property (tx_fifo_empty && !s_q.prev_empty |=> s_q.sticky[`HTF_EV_EMPTY])
    else $error("empty rise not latched");

  // Space flag rising is latched
  AST_SPACE_RISE: assert property (tx_space_ok && !s_q.prev_space |=> s_q.sticky[`HTF_EV_SPACE])
    else $error("space rise not latched");

  // An enabled event with the port enabled raises the interrupt
  AST_IRQ_SET: assert property (port_global_irq_en_in && (s_q.sticky & s_q.ien) != '0 |-> irq_out)
    else $error("enabled event gave no interrupt");

  // Read data stand only in the cycle after a read strobe
  AST_RDATA_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("read data outside read cycle");

  // Occupancy never passes the depth
  AST_CNT_BOUND: assert property (s_q.cnt <= `HTF_DEPTH)
    else $error("occupancy beyond depth");

  // Unused status bits read zero
  AST_STAT_TOP: assert property (reg_rd_in && reg_hit(reg_addr_in, `HTF_OFF_STAT)
      |=> reg_rdata_out[15:14] == 2'b00 && reg_rdata_out[7:3] == 5'h00)
    else $error("unused status bits set");

  // A held FIFO sends no bits
  AST_HELD_SILENT: assert property (s_q.mode == HTF_HELD |=> !tx_bit_valid_out)
    else $error("bit sent while held");

  // Writes during RAM power-up are discarded
  AST_PWRUP_DROP: assert property (s_q.mode == HTF_PWRUP && data_wr_hi |=> s_q.cnt == `HTF_ZERO_CNT)
    else $error("write stored during power-up");

endmodule : htf_tx_fifo

// file: testbench/htf_bit_puller.sv
/*
  Packet processor stand-in: asks the FIFO for one serial bit per request.
  Assumes the FIFO's clock and reset; requests change just after a rising edge.
*/
`timescale 1ns/1ps

module htf_bit_puller (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  input wire logic slow_in,
  output logic tx_bit_req_out
);
  logic [1:0] gap_q;

  // One request a cycle, or one in three when slow
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gap_q <= 2'h0;
      tx_bit_req_out <= 1'b0;
    end else begin
      gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
      tx_bit_req_out <= run_in && (!slow_in || gap_q == 2'h0);
    end
  end
endmodule : htf_bit_puller

// file: testbench/hdlc_tx_fifo_host_side_bench.sv
/*
  Self-checking bench of the transmit FIFO: register tasks, a bit puller,
  expected values kept in queues and compared by a watcher.
  Assumes the design and package under core/ and the bit puller.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin num_errors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end

module hdlc_tx_fifo_host_side_bench;
  import htf_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] be = 2'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic gien = 1'b0;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic msb = 1'b0;
  logic rd_seen = 1'b0;
  logic req, tbit, tval, tend, irq;
  logic [15:0] rdata, exp_r;
  logic [1:0] exp_b;
  logic [15:0] rd_q[$];
  logic [1:0] bit_q[$];
  int num_errors = 0;
  int n_checks = 0;

  ////////////////////////////////////////////////////////////
  // Clock, design and bit puller
  always #4 mclk_in = ~mclk_in;

  htf_tx_fifo DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_be_in(be), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .port_global_irq_en_in(gien),
    .tx_bit_req_in(req), .tx_bit_out(tbit), .tx_bit_valid_out(tval), .tx_bit_pkt_end_out(tend), .irq_out(irq));

  htf_bit_puller puller (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .run_in(run), .slow_in(slow),
    .tx_bit_req_out(req));

  ////////////////////////////////////////////////////////////
  // Watcher: read data one cycle after the strobe, and every serial bit
  always @(posedge mclk_in) rd_seen <= rd;

  always @(negedge mclk_in) begin
    if (rd_seen) begin
      exp_r = rd_q.pop_front();
      `CHK("reg_rdata_out", exp_r, rdata)
    end
    if (tval) begin
      exp_b = bit_q.pop_front();
      `CHK("tx_bit", exp_b, {tend, tbit})
    end
  end

  ////////////////////////////////////////////////////////////
  // Bus and traffic tasks
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk_in);
    rd_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
  endtask : rd_reg

  // Push a byte; note its bits in serial order when it is stored
  task automatic push_byte(input logic [7:0] b, input logic last, input logic keep);
    wr_reg(8'hA2, {b, 7'h00, last}, 2'h3);
    for (int i = 0; i < 8; i++) begin
      if (keep) bit_q.push_back({last && i == 7, b[msb ? 7 - i : i]});
    end
  endtask : push_byte

  task automatic drain(input logic s);
    slow <= s;
    run <= 1'b1;
    for (int i = 0; i < 9000 && bit_q.size() != 0; i++) @(posedge mclk_in);
    repeat (4) @(posedge mclk_in);
    run <= 1'b0;
    `CHK("bits_left", 0, bit_q.size())
  endtask : drain

  task automatic chk_irq(input logic e);
    repeat (2) @(negedge mclk_in);
    `CHK("irq_out", e, irq)
  endtask : chk_irq

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h163F));
    repeat (6) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    gien <= 1'b1;
    rd_reg(8'hA4, 16'h2003);
    rd_reg(8'hA6, 16'h0000);
    rd_reg(8'hA8, 16'h0000);
    rd_reg(8'hAA, 16'h0000);
    wr_reg(8'hA4, 16'hFFFF, 2'h3);
    rd_reg(8'hA4, 16'h2003);
    $display("test reset_values done");
    // Tag alone stores nothing; then a three-byte packet, LSB first
    wr_reg(8'hA2, 16'h0001, 2'h1);
    rd_reg(8'hA4, 16'h2003);
    for (int i = 0; i < 3; i++) push_byte(8'($urandom), i == 2, 1'b1);
    rd_reg(8'hA4, 16'h1F01);
    rd_reg(8'hA2, 16'h0000);
    drain(1'b0);
    rd_reg(8'hA6, 16'h000A);
    wr_reg(8'hA8, 16'h0008, 2'h3);
    chk_irq(1'b1);
    gien <= 1'b0;
    chk_irq(1'b0);
    gien <= 1'b1;
    wr_reg(8'hA6, 16'h003F, 2'h3);
    chk_irq(1'b0);
    rd_reg(8'hA6, 16'h0000);
    // MSB first, slow puller
    wr_reg(8'hA0, 16'h0008, 2'h1);
    msb = 1'b1;
    push_byte(8'($urandom), 1'b0, 1'b1);
    push_byte(8'($urandom), 1'b1, 1'b1);
    drain(1'b1);
    wr_reg(8'hA6, 16'h003F, 2'h3);
    $display("test packets done");
    // Soft reset ignores writes and marks empty and space on release
    wr_reg(8'hA0, 16'h0009, 2'h1);
    push_byte(8'h5A, 1'b1, 1'b0);
    wr_reg(8'hA0, 16'h0008, 2'h1);
    repeat (8) @(posedge mclk_in);
    rd_reg(8'hA6, 16'h0003);
    rd_reg(8'hA4, 16'h2003);
    wr_reg(8'hA6, 16'h003F, 2'h3);
    push_byte(8'($urandom), 1'b1, 1'b1);
    drain(1'b0);
    wr_reg(8'hA6, 16'h003F, 2'h3);
    $display("test soft_reset done");
    // Fill to full, one write too many, then drain everything
    wr_reg(8'hA0, 16'h0000, 2'h1);
    msb = 1'b0;
    for (int i = 0; i < 257; i++) begin
      push_byte(8'($urandom), i >= 255, i < 256);
      if (i == 126) rd_reg(8'hA4, 16'h1001);
      if (i == 127) rd_reg(8'hA4, 16'h1000);
      if (i == 254) rd_reg(8'hA4, 16'h0000);
      if (i == 255) rd_reg(8'hA4, 16'h0004);
    end
    rd_reg(8'hA6, 16'h0024);
    drain(1'b0);
    rd_reg(8'hA6, 16'h002F);
    wr_reg(8'hA6, 16'h003F, 2'h3);
    $display("test fill_overflow done");
    // Packet left open: the next byte is missing
    push_byte(8'($urandom), 1'b0, 1'b1);
    drain(1'b0);
    rd_reg(8'hA6, 16'h0012);
    wr_reg(8'hA8, 16'h0010, 2'h3);
    chk_irq(1'b1);
    $display("test underflow done");
    finish_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule : hdlc_tx_fifo_host_side_bench
